/* core/mcc_classifier.sv */
// Machine-check error classifier: captures error sources, picks a code, exposes over APB.
// Assumes error sources are synchronous to pclk and each event is a one-cycle pulse.
//
// Overview of operation
// - Tag control parity: status bit 2, code 20B
// - Status bit 4: DMA one, CPU zero
// - Bits 8:6 hold DMA or CPU command
// - Status bit 5 marks victim write-back
// - Nonexistent address: bit 3, code 20C
// - NMI/SERR sets irq bit 5, code 20D
// - Bridge bit 6 ISA, bit 7 PCI
// - CPU tag address parity: bit 3, code 80
// - CPU tag control parity: code 82
// - Bus status bits 6:4 hold cycle type
// - Error address bits 7:0 captured
// - Tag capture bit 0 is cache hit
// - Bits 1-4: parity, dirty, shared, valid
// - Tag bits 33:17 at 21:5, parity 22
// - Hard-error ack: bit 1, code 84
// - Soft-error ack: bit 2, code 8C
// - Check with no error bit: code 8A
// - Breakpoint in debug mode: code 8E
// - ECC codes 86, 88 never raised
`timescale 1ns/10ps
module mcc_classifier
  import mcc_pkg::*;
(
  // APB clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Cache controller error events
  input  wire logic        cc_tag_addr_par_err,
  input  wire logic        cc_tag_ctl_par_err,
  input  wire logic        cc_nxm_err,
  input  wire logic        cc_is_dma,
  input  wire logic        cc_victim,
  input  wire logic [2:0]  dma_command_code,
  input  wire logic [2:0]  cpu_request_code,
  // CPU bus interface error events
  input  wire logic        biu_tag_addr_par_err,
  input  wire logic        biu_tag_ctl_par_err,
  input  wire logic        biu_ack_valid,
  input  wire logic [2:0]  cycle_ack_lines,
  input  wire logic [2:0]  cpu_cycle_request_lines,
  input  wire logic [7:0]  biu_phys_addr,
  // Backup tag snapshot
  input  wire logic        btag_hit,
  input  wire logic        tag_ctl_parity,
  input  wire logic        tag_dirty_flag,
  input  wire logic        tag_shared_flag,
  input  wire logic        tag_valid_flag,
  input  wire logic [16:0] btag_addr,
  input  wire logic        btag_data_par,
  // I/O bus and core events
  input  wire logic        io_nmi_serr,
  input  wire logic        io_src_isa,
  input  wire logic        io_src_pci,
  input  wire logic        mchk_request,
  input  wire logic        debug_breakpoint,
  // Classification outputs
  output logic             mchk_valid,
  output logic [11:0]      mchk_code
);
  import mcc_pkg::*;

  // Registers and their next values
  logic [31:0] cache_ctrl_error_status_reg;
  logic [31:0] cache_ctrl_error_status_next;
  logic [31:0] cpu_bus_error_status_reg;
  logic [31:0] cpu_bus_error_status_next;
  logic [31:0] cpu_bus_error_address_reg;
  logic [31:0] cpu_bus_error_address_next;
  logic [31:0] backup_tag_capture_reg;
  logic [31:0] backup_tag_capture_next;
  logic [31:0] host_irq_request_reg;
  logic [31:0] host_irq_request_next;
  logic [31:0] system_io_bridge_reg;
  logic [31:0] system_io_bridge_next;
  logic [31:0] load_store_unit_control_reg;
  logic [31:0] prdata_next;
  logic [11:0] mchk_code_reg;
  logic [11:0] mchk_code_next;
  mcc_state_t  state_reg;
  mcc_state_t  state_next;
  // Bus and event decode
  logic        wr_en;
  logic        rd_en;
  logic        sw_clear;
  logic        hard_ack;
  logic        soft_ack;
  logic        cc_event;
  logic        biu_event;
  logic        any_event;
  logic        err_present;
  logic        capture_open;
  logic        mchk_take;

  // APB decode; writes land in the access phase
  assign wr_en    = psel && penable && pwrite;
  assign rd_en    = psel && !penable && !pwrite;
  assign sw_clear = wr_en && (paddr == MCC_OFF_CLEAR) && (pwdata == MCC_CLEAR_KEY);

  // Acknowledge codes of the failing CPU cycle
  assign hard_ack = biu_ack_valid && (cycle_ack_lines == ACK_HARD_ERROR);
  // Soft-error acks only count when software enabled them
  assign soft_ack = biu_ack_valid && (cycle_ack_lines == ACK_SOFT_ERROR)
                    && load_store_unit_control_reg[LSU_SOFT_ACK_EN];

  // Event grouping
  assign cc_event    = cc_tag_addr_par_err || cc_tag_ctl_par_err || cc_nxm_err;
  assign biu_event   = biu_tag_addr_par_err || biu_tag_ctl_par_err || hard_ack || soft_ack;
  assign any_event   = cc_event || biu_event || io_nmi_serr;
  assign err_present = (cache_ctrl_error_status_reg != MCC_ZERO)
                       || (cpu_bus_error_status_reg != MCC_ZERO)
                       || host_irq_request_reg[HI_NMI_SERR];

  // Capture window: idle, or a clear in the same cycle (set beats clear)
  assign capture_open = (state_reg == MCC_IDLE) || sw_clear;
  // Whatever raises a machine check also closes the window
  assign mchk_take    = capture_open
                        && (any_event || debug_breakpoint || (mchk_request && !err_present));

  // APB: zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  // No error responses; unmapped words read zero instead
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= 1'b0;
    end
  end

  // Read mux
  always_comb begin
    prdata_next = MCC_ZERO;
    case (paddr)
      MCC_OFF_CC_STAT:  prdata_next = cache_ctrl_error_status_reg;
      MCC_OFF_CPU_BUS_ERROR_STATUS: prdata_next = cpu_bus_error_status_reg;
      MCC_OFF_CPU_BUS_ERROR_ADDRESS: prdata_next = cpu_bus_error_address_reg;
      MCC_OFF_BTAG:     prdata_next = backup_tag_capture_reg;
      MCC_OFF_HOST_IRQ_REQUEST:     prdata_next = host_irq_request_reg;
      MCC_OFF_SIOB:     prdata_next = system_io_bridge_reg;
      MCC_OFF_MCODE:    prdata_next = {20'h0_0000, mchk_code_reg};
      MCC_OFF_LSU_CTL:  prdata_next = load_store_unit_control_reg;
      default:          prdata_next = MCC_ZERO;
    endcase
  end

  // Read data latched in the setup cycle, stands through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= MCC_ZERO;
    end else if (rd_en) begin
      prdata <= prdata_next;
    end
  end

  // Soft-ack enable and spare control bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_store_unit_control_reg <= MCC_ZERO;
    end else if (wr_en && paddr == MCC_OFF_LSU_CTL) begin
      load_store_unit_control_reg <= pwdata;
    end
  end

  // Lock: first machine check freezes cache, bus and tag context so a later one cannot overwrite it
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      MCC_IDLE: begin
        if (mchk_take) begin
          state_next = MCC_LOCKED;
        end
      end
      MCC_LOCKED: begin
        if (sw_clear && !mchk_take) begin
          state_next = MCC_IDLE;
        end
      end
      default: begin
        state_next = MCC_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= MCC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Cache controller status; new event wins over clear
  always_comb begin
    cache_ctrl_error_status_next = cache_ctrl_error_status_reg;
    if (cc_event && capture_open) begin
      cache_ctrl_error_status_next                  = MCC_ZERO;
      cache_ctrl_error_status_next[CC_TAG_ADDR_PAR] = cc_tag_addr_par_err;
      cache_ctrl_error_status_next[CC_TAG_CTL_PAR]  = cc_tag_ctl_par_err;
      cache_ctrl_error_status_next[CC_NXM]          = cc_nxm_err;
      cache_ctrl_error_status_next[CC_DMA]          = cc_is_dma;
      cache_ctrl_error_status_next[CC_VICTIM]       = cc_victim;
      cache_ctrl_error_status_next[CC_CMD_HI:CC_CMD_LO] =
        cc_is_dma ? dma_command_code : cpu_request_code;
    end else if (sw_clear) begin
      cache_ctrl_error_status_next = MCC_ZERO;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cache_ctrl_error_status_reg <= MCC_ZERO;
    end else begin
      cache_ctrl_error_status_reg <= cache_ctrl_error_status_next;
    end
  end

  // CPU bus status: termination and cycle type of the failing cycle
  always_comb begin
    cpu_bus_error_status_next = cpu_bus_error_status_reg;
    if (biu_event && capture_open) begin
      cpu_bus_error_status_next             = MCC_ZERO;
      cpu_bus_error_status_next[BS_HARD]    = hard_ack;
      cpu_bus_error_status_next[BS_SOFT]    = soft_ack;
      cpu_bus_error_status_next[BS_TAG_PAR] = biu_tag_addr_par_err
                                              || biu_tag_ctl_par_err;
      cpu_bus_error_status_next[BS_CYC_HI:BS_CYC_LO] = cpu_cycle_request_lines;
    end else if (sw_clear) begin
      cpu_bus_error_status_next = MCC_ZERO;
    end
  end

  // Error address: low physical address bits of the failing cycle
  always_comb begin
    cpu_bus_error_address_next = cpu_bus_error_address_reg;
    if (biu_event && capture_open) begin
      cpu_bus_error_address_next               = MCC_ZERO;
      cpu_bus_error_address_next[BA_ADDR_HI:0] = biu_phys_addr;
    end else if (sw_clear) begin
      cpu_bus_error_address_next = MCC_ZERO;
    end
  end

  // Tag snapshot; shared flag kept although this system does not use it
  always_comb begin
    backup_tag_capture_next = backup_tag_capture_reg;
    if (biu_event && capture_open) begin
      backup_tag_capture_next                      = MCC_ZERO;
      backup_tag_capture_next[BT_HIT]              = btag_hit;
      backup_tag_capture_next[BT_CTL_PAR]          = tag_ctl_parity;
      backup_tag_capture_next[BT_DIRTY]            = tag_dirty_flag;
      backup_tag_capture_next[BT_SHARED]           = tag_shared_flag;
      backup_tag_capture_next[BT_VALID]            = tag_valid_flag;
      backup_tag_capture_next[BT_TAG_HI:BT_TAG_LO] = btag_addr;
      backup_tag_capture_next[BT_DATA_PAR]         = btag_data_par;
    end else if (sw_clear) begin
      backup_tag_capture_next = MCC_ZERO;
    end
  end

  // CPU bus side registers share one reset and load point
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_bus_error_status_reg  <= MCC_ZERO;
      cpu_bus_error_address_reg <= MCC_ZERO;
      backup_tag_capture_reg    <= MCC_ZERO;
    end else begin
      cpu_bus_error_status_reg  <= cpu_bus_error_status_next;
      cpu_bus_error_address_reg <= cpu_bus_error_address_next;
      backup_tag_capture_reg    <= backup_tag_capture_next;
    end
  end

  // Host irq request: sticky, set beats clear
  always_comb begin
    host_irq_request_next = host_irq_request_reg;
    if (sw_clear) begin
      host_irq_request_next = MCC_ZERO;
    end
    if (io_nmi_serr) begin
      host_irq_request_next[HI_NMI_SERR] = 1'b1;
    end
  end

  // Bridge source bits: sticky, set beats clear
  always_comb begin
    system_io_bridge_next = system_io_bridge_reg;
    if (sw_clear) begin
      system_io_bridge_next = MCC_ZERO;
    end
    if (io_nmi_serr) begin
      system_io_bridge_next[SB_ISA] = system_io_bridge_next[SB_ISA] || io_src_isa;
      system_io_bridge_next[SB_PCI] = system_io_bridge_next[SB_PCI] || io_src_pci;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_irq_request_reg <= MCC_ZERO;
      system_io_bridge_reg <= MCC_ZERO;
    end else begin
      host_irq_request_reg <= host_irq_request_next;
      system_io_bridge_reg <= system_io_bridge_next;
    end
  end

  // Code priority; ECC codes exist only as constants and are never selected
  always_comb begin
    mchk_code_next = MC_UNKNOWN;
    if (debug_breakpoint) begin
      mchk_code_next = MC_BUGCHECK;
    end else if (hard_ack) begin
      mchk_code_next = MC_HARD;
    end else if (soft_ack) begin
      mchk_code_next = MC_SOFT;
    end else if (biu_tag_addr_par_err) begin
      mchk_code_next = MC_BIU_TPAR;
    end else if (biu_tag_ctl_par_err) begin
      mchk_code_next = MC_BIU_TCPAR;
    end else if (cc_tag_addr_par_err) begin
      mchk_code_next = MC_TAG_APAR;
    end else if (cc_tag_ctl_par_err) begin
      mchk_code_next = MC_CC_TCPAR;
    end else if (cc_nxm_err) begin
      mchk_code_next = MC_NXM;
    end else if (io_nmi_serr) begin
      mchk_code_next = MC_IOBUS;
    end
  end

  // Code held until software clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mchk_code_reg <= MC_NONE;
    end else if (mchk_take) begin
      mchk_code_reg <= mchk_code_next;
    end else if (sw_clear) begin
      mchk_code_reg <= MC_NONE;
    end
  end

  // Valid flag follows the lock so context and code always agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mchk_valid <= 1'b0;
    end else if (mchk_take) begin
      mchk_valid <= 1'b1;
    end else if (sw_clear) begin
      mchk_valid <= 1'b0;
    end
  end

  assign mchk_code = mchk_code_reg;
endmodule

/* core/mcc_pkg.sv */
// Package for the machine-check error classifier: register map, field layout, codes.
// Assumes a 32-bit APB register bus with word-aligned registers.
package mcc_pkg;
  // Register byte offsets
  localparam logic [7:0] MCC_OFF_CC_STAT   = 8'h00;
  localparam logic [7:0] MCC_OFF_CPU_BUS_ERROR_STATUS  = 8'h04;
  localparam logic [7:0] MCC_OFF_CPU_BUS_ERROR_ADDRESS  = 8'h08;
  localparam logic [7:0] MCC_OFF_BTAG      = 8'h0c;
  localparam logic [7:0] MCC_OFF_HOST_IRQ_REQUEST      = 8'h10;
  localparam logic [7:0] MCC_OFF_SIOB      = 8'h14;
  localparam logic [7:0] MCC_OFF_MCODE     = 8'h18;
  localparam logic [7:0] MCC_OFF_CLEAR     = 8'h1c;
  localparam logic [7:0] MCC_OFF_LSU_CTL   = 8'h20;
  // Cache controller status fields
  localparam int CC_TAG_ADDR_PAR = 1;
  localparam int CC_TAG_CTL_PAR  = 2;
  localparam int CC_NXM          = 3;
  localparam int CC_DMA          = 4;
  localparam int CC_VICTIM       = 5;
  localparam int CC_CMD_LO       = 6;
  localparam int CC_CMD_HI       = 8;
  // CPU bus status fields
  localparam int BS_HARD         = 1;
  localparam int BS_SOFT         = 2;
  localparam int BS_TAG_PAR      = 3;
  localparam int BS_CYC_LO       = 4;
  localparam int BS_CYC_HI       = 6;
  localparam int BA_ADDR_HI      = 7;
  // Backup tag capture fields
  localparam int BT_HIT          = 0;
  localparam int BT_CTL_PAR      = 1;
  localparam int BT_DIRTY        = 2;
  localparam int BT_SHARED       = 3;
  localparam int BT_VALID        = 4;
  localparam int BT_TAG_LO       = 5;
  localparam int BT_TAG_HI       = 21;
  localparam int BT_DATA_PAR     = 22;
  // Other fields
  localparam int HI_NMI_SERR     = 5;
  localparam int SB_ISA          = 6;
  localparam int SB_PCI          = 7;
  localparam int LSU_SOFT_ACK_EN = 2;
  // Cycle acknowledge codes
  localparam logic [2:0] ACK_HARD_ERROR = 3'h2;
  localparam logic [2:0] ACK_SOFT_ERROR = 3'h3;
  // Machine-check codes
  localparam logic [11:0] MC_NONE       = 12'h000;
  localparam logic [11:0] MC_TAG_APAR   = 12'h20a;
  localparam logic [11:0] MC_CC_TCPAR   = 12'h20b;
  localparam logic [11:0] MC_NXM        = 12'h20c;
  localparam logic [11:0] MC_IOBUS      = 12'h20d;
  localparam logic [11:0] MC_BIU_TPAR   = 12'h080;
  localparam logic [11:0] MC_BIU_TCPAR  = 12'h082;
  localparam logic [11:0] MC_HARD       = 12'h084;
  localparam logic [11:0] MC_ECC_C      = 12'h086;
  localparam logic [11:0] MC_ECC_NC     = 12'h088;
  localparam logic [11:0] MC_UNKNOWN    = 12'h08a;
  localparam logic [11:0] MC_SOFT       = 12'h08c;
  localparam logic [11:0] MC_BUGCHECK   = 12'h08e;
  localparam logic [31:0] MCC_ZERO      = 32'h0000_0000;
  localparam logic [31:0] MCC_CLEAR_KEY = 32'h0000_0001;
  typedef enum logic [1:0] {
    MCC_IDLE   = 2'b00,
    MCC_LOCKED = 2'b01
  } mcc_state_t;
endpackage

/* test/mcc_classifier_chk.sv */
// Checker: machine-check code selection and hold.
// Assumes single one-cycle events arriving from the idle state.
`timescale 1ns/10ps
module mcc_classifier_chk
  import mcc_pkg::*;
(
  // Clock, reset and APB
  input wire logic        pclk, presetn, psel, penable, pwrite,
  input wire logic [7:0]  paddr,
  // Error events
  input wire logic        cc_tag_addr_par_err, cc_tag_ctl_par_err, cc_nxm_err,
  input wire logic        biu_tag_addr_par_err, biu_tag_ctl_par_err, biu_ack_valid,
  input wire logic [2:0]  cycle_ack_lines,
  input wire logic        io_nmi_serr, mchk_request, debug_breakpoint,
  // Classification
  input wire logic        mchk_valid,
  input wire logic [11:0] mchk_code
);
  logic [8:0] ev;
  logic       clr;
  // Hard ack is an event only with its qualifier
  assign ev  = {debug_breakpoint, biu_ack_valid && cycle_ack_lines == ACK_HARD_ERROR,
                biu_tag_addr_par_err, biu_tag_ctl_par_err, cc_tag_addr_par_err,
                cc_tag_ctl_par_err, cc_nxm_err, io_nmi_serr, mchk_request};
  assign clr = psel && penable && pwrite && paddr == MCC_OFF_CLEAR;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_tcpar; !mchk_valid && ev == 9'h008 |=> mchk_code == MC_CC_TCPAR; endproperty
  a_tcpar: assert property (p_tcpar) else $error("tag control code wrong");
  property p_nxm; !mchk_valid && ev == 9'h004 |=> mchk_code == MC_NXM; endproperty
  a_nxm: assert property (p_nxm) else $error("bad address code wrong");
  property p_io; !mchk_valid && ev == 9'h002 |=> mchk_code == MC_IOBUS; endproperty
  a_io: assert property (p_io) else $error("io bus code wrong");
  property p_btp; !mchk_valid && ev == 9'h040 |=> mchk_code == MC_BIU_TPAR; endproperty
  a_btp: assert property (p_btp) else $error("cpu tag address code wrong");
  property p_btc; !mchk_valid && ev == 9'h020 |=> mchk_code == MC_BIU_TCPAR; endproperty
  a_btc: assert property (p_btc) else $error("cpu tag control code wrong");
  property p_hard; !mchk_valid && ev == 9'h080 |=> mchk_valid && mchk_code == MC_HARD; endproperty
  a_hard: assert property (p_hard) else $error("hard ack code wrong");
  property p_unk; !mchk_valid && ev == 9'h001 |=> mchk_code == MC_UNKNOWN; endproperty
  a_unk: assert property (p_unk) else $error("unknown code wrong");
  property p_bug; !mchk_valid && ev[8] |=> mchk_code == MC_BUGCHECK; endproperty
  a_bug: assert property (p_bug) else $error("bugcheck code wrong");
  property p_ecc; mchk_code != MC_ECC_C && mchk_code != MC_ECC_NC; endproperty
  a_ecc: assert property (p_ecc) else $error("ecc code raised");
  property p_hold; mchk_valid && !clr |=> mchk_valid && $stable(mchk_code); endproperty
  a_hold: assert property (p_hold) else $error("code not held");
endmodule
bind mcc_classifier mcc_classifier_chk u_chk (.*);

/* test/mcc_err_src.sv */
// Error-source model: cache controller, CPU bus unit, I/O and core event pins.
// Assumes go, sel and ctx change just after a pclk edge; one event per pulse.
`timescale 1ns/10ps
module mcc_err_src (
  // Request from the bench
  input  wire logic        go,
  input  wire logic [3:0]  sel,
  input  wire logic [63:0] ctx,
  // Event pins and their context
  output logic cc_tag_addr_par_err, cc_tag_ctl_par_err, cc_nxm_err, cc_is_dma, cc_victim,
  output logic biu_tag_addr_par_err, biu_tag_ctl_par_err, biu_ack_valid, btag_hit,
  output logic tag_ctl_parity, tag_dirty_flag, tag_shared_flag, tag_valid_flag, btag_data_par,
  output logic io_nmi_serr, io_src_isa, io_src_pci, mchk_request, debug_breakpoint,
  output logic [2:0]  dma_command_code, cpu_request_code, cycle_ack_lines,
  output logic [2:0]  cpu_cycle_request_lines,
  output logic [7:0]  biu_phys_addr,
  output logic [16:0] btag_addr
);
  logic [63:0] c;
  // Context is only valid with its pulse; elsewhere it shows junk
  assign c = go ? ctx : ~ctx;
  assign {debug_breakpoint, mchk_request, io_nmi_serr, biu_ack_valid, biu_tag_ctl_par_err,
          biu_tag_addr_par_err, cc_nxm_err, cc_tag_ctl_par_err, cc_tag_addr_par_err} =
         go ? 9'h001 << sel : 9'h000;
  assign {btag_addr, cycle_ack_lines, io_src_pci, io_src_isa, btag_data_par, tag_valid_flag,
          tag_shared_flag, tag_dirty_flag, tag_ctl_parity, btag_hit, biu_phys_addr,
          cpu_cycle_request_lines, cpu_request_code, dma_command_code, cc_victim, cc_is_dma} =
         {c[47:31], c[29:0]};
endmodule

/* test/mcc_classifier_tb_top.sv */
// Testbench: APB master, error-source model, queued read checks.
// Assumes the mcc_pkg register map; unmapped words read zero.
`timescale 1ns/10ps
module mcc_classifier_tb_top;
  import mcc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, mchk_valid, go;
  logic        cc_tag_addr_par_err, cc_tag_ctl_par_err, cc_nxm_err, cc_is_dma, cc_victim;
  logic        biu_tag_addr_par_err, biu_tag_ctl_par_err, biu_ack_valid, btag_hit;
  logic        tag_ctl_parity, tag_dirty_flag, tag_shared_flag, tag_valid_flag, btag_data_par;
  logic        io_nmi_serr, io_src_isa, io_src_pci, mchk_request, debug_breakpoint;
  logic [2:0]  dma_command_code, cpu_request_code, cycle_ack_lines, cpu_cycle_request_lines;
  logic [7:0]  paddr, biu_phys_addr;
  logic [16:0] btag_addr;
  logic [11:0] mchk_code;
  logic [3:0]  sel;
  logic [31:0] pwdata, prdata, e, m;
  logic [63:0] ctx, c;
  logic [31:0] exp_q[$], msk_q[$];
  int          fail_count, n_tests;

  mcc_classifier DUT (.*);
  mcc_err_src    u_src (.*);

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic end_sim();
    $display("Checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] k);
    exp_q.push_back(x);
    msk_q.push_back(k);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic mc(input logic [11:0] x);
    rd(MCC_OFF_MCODE, {20'h0, x}, 32'hfff);
  endtask

  task automatic ev(input logic [3:0] s, input logic [63:0] v);
    @(posedge pclk);
    go  <= 1'b1;
    sel <= s;
    ctx <= v;
    @(posedge pclk);
    go  <= 1'b0;
  endtask

  // Read monitor: oldest note against each completed read
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      n_tests++;
      if (((prdata ^ e) & m) !== 32'h0) begin
        fail_count++;
        $display("BAD reg %h exp %h got %h", paddr, e & m, prdata & m);
      end
      if (pslverr !== 1'b0) begin
        fail_count++;
        $display("BAD pslverr exp 0 got %b", pslverr);
      end
    end
  end

  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    end_sim();
  end

  initial begin
    {psel, penable, pwrite, go, presetn} = 5'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    sel = 4'h0;
    ctx = 64'h0;
    fail_count = 0;
    n_tests = 0;
    void'($urandom(32'h6c32e690));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(MCC_OFF_CC_STAT, 32'h0, 32'hffffffff);
    rd(MCC_OFF_BTAG, 32'h0, 32'hffffffff);
    mc(MC_NONE);
    apb(1'b1, 8'h24, 32'hffffffff);
    rd(8'h24, 32'h0, 32'hffffffff);
    for (int i = 0; i < 4; i++) begin
      c = {$urandom, $urandom};
      c[0] = i[1];
      ev(i[0] ? 4'h2 : 4'h1, c);
      rd(MCC_OFF_CC_STAT, {23'h0, c[0] ? c[4:2] : c[7:5], c[1:0], i[0], !i[0], 2'h0},
         32'h1fc);
      mc(i[0] ? MC_NXM : MC_CC_TCPAR);
      apb(1'b1, MCC_OFF_CLEAR, MCC_CLEAR_KEY);
    end
    for (int i = 3; i < 6; i++) begin
      c = {$urandom, $urandom};
      c[29:27] = ACK_HARD_ERROR;
      ev(4'(i), c);
      if (i < 5) begin
        rd(MCC_OFF_CPU_BUS_ERROR_STATUS, {25'h0, c[10:8], 4'h8}, 32'h7e);
        rd(MCC_OFF_CPU_BUS_ERROR_ADDRESS, {24'h0, c[18:11]}, 32'hff);
        rd(MCC_OFF_BTAG, {9'h0, c[24], c[47:31], c[23:19]}, 32'h7fffff);
      end else begin
        rd(MCC_OFF_CPU_BUS_ERROR_STATUS, 32'h2, 32'he);
      end
      mc(i == 3 ? MC_BIU_TPAR : i == 4 ? MC_BIU_TCPAR : MC_HARD);
      apb(1'b1, MCC_OFF_CLEAR, MCC_CLEAR_KEY);
    end
    for (int i = 1; i < 4; i++) begin
      c = {$urandom, $urandom};
      c[26:25] = i[1:0];
      ev(4'h6, c);
      rd(MCC_OFF_HOST_IRQ_REQUEST, 32'h20, 32'h20);
      rd(MCC_OFF_SIOB, {24'h0, c[26:25], 6'h0}, 32'hc0);
      mc(MC_IOBUS);
      apb(1'b1, MCC_OFF_CLEAR, MCC_CLEAR_KEY);
    end
    c[29:27] = ACK_SOFT_ERROR;
    apb(1'b1, MCC_OFF_LSU_CTL, 32'h0);
    ev(4'h5, c);
    mc(MC_NONE);
    apb(1'b1, MCC_OFF_LSU_CTL, 32'h4);
    rd(MCC_OFF_LSU_CTL, 32'h4, 32'h4);
    ev(4'h5, c);
    rd(MCC_OFF_CPU_BUS_ERROR_STATUS, 32'h4, 32'h6);
    mc(MC_SOFT);
    apb(1'b1, MCC_OFF_CLEAR, MCC_CLEAR_KEY);
    apb(1'b1, MCC_OFF_LSU_CTL, 32'h0);
    ev(4'h7, c);
    mc(MC_UNKNOWN);
    apb(1'b1, MCC_OFF_CLEAR, MCC_CLEAR_KEY);
    ev(4'h8, c);
    ev(4'h2, c);
    mc(MC_BUGCHECK);
    rd(MCC_OFF_CC_STAT, 32'h0, 32'h8);
    apb(1'b1, MCC_OFF_CLEAR, MCC_CLEAR_KEY);
    repeat (4) @(posedge pclk);
    end_sim();
  end
endmodule
